// [hw/ppmc_defines.svh]
`ifndef PPMC_DEFINES_SVH
`define PPMC_DEFINES_SVH

// register byte addresses
`define PPMC_ADDR_CTRL 4'h0
`define PPMC_ADDR_STAT 4'h4

// control word fields
`define PPMC_CTRL_SOG 0
`define PPMC_CTRL_SYNC_OUT 1
`define PPMC_CTRL_MATCH0 2
`define PPMC_CTRL_MATCH1 3
`define PPMC_CTRL_RATE 4
`define PPMC_CTRL_FMT_LO 5
`define PPMC_CTRL_FMT_HI 6
`define PPMC_CTRL_WIDTH 7
`define PPMC_CTRL_RESET 7'h00

// status word fields
`define PPMC_STAT_SEL 0
`define PPMC_STAT_ACTIVE 1

// pixel formats
`define PPMC_FMT_24 2'h0
`define PPMC_FMT_15 2'h1
`define PPMC_FMT_8 2'h2

// bus answers
`define PPMC_RESP_OKAY 2'h0
`define PPMC_RESP_SLVERR 2'h2

// output codes
`define PPMC_DAC_ZERO 10'h000

`endif

// [hw/ppmc_pkg.sv]
package ppmc_pkg;

  typedef struct packed {
    logic [23:0] pix_a;
    logic [23:0] pix_b;
    logic [1:0] ps_a;
    logic [1:0] ps_b;
    logic sync;
    logic blank;
  } ppmc_pair_s;

  typedef struct packed {
    logic [1:0] fmt;
    logic rate_1to1;
    logic select_match_bit1;
    logic select_match_bit0;
    logic sync_output_enable;
    logic sync_on_green_enable;
  } ppmc_ctrl_s;

  typedef enum logic [2:0] {
    PPMC_IDLE = 3'b001,
    PPMC_FIRST = 3'b010,
    PPMC_SECOND = 3'b100
  } ppmc_state_e;

endpackage

// [hw/ppmc_sync.sv]
`timescale 1ns/1ns
`default_nettype none

module ppmc_sync #(
  parameter int W = 1
) (
  // destination clock
  input wire logic clk,
  // level from another domain
  input wire logic [W-1:0] d,
  // synchronised level
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  always_ff @(posedge clk) begin
    meta_r <= d;
    q <= meta_r;
  end

endmodule // ppmc_sync

`default_nettype wire

// [hw/ppmc_top.sv]
// How it works
// - two parallel 24-bit colour ports give 48 inputs, two pixels per capture in 2:1, port A only in 1:1.
// - colour data is captured on every rising edge of the latch strobe.
// - sync, blank and palette selects are captured on the same strobe edge.
// - pipeline runs on pixel clock; strobe may have any phase to it.
// - generated strobe output can feed the strobe input at the right rate.
// - latched blank forces blanking level, latched sync drives sync level.
// - sync is put on green only while sync-on-green enable is 1.
// - digital sync output, pipeline aligned, driven while its enable is 1.
// - selected only when both palette select bits equal the match bits.
// - deselected pixels force all three current outputs to zero.
// - palette selects are multiplexed per pixel exactly like colour data.
// - in 1:1 the strobe carries the pixel clock and clocks the capture.
// - 24-bit, 15-bit and 8-bit formats work in both multiplex rates.
// - one rate bit selects 2:1 or 1:1; strobe output follows it.
`include "ppmc_defines.svh"
`timescale 1ns/1ns
`default_nettype none

module ppmc_top
  import ppmc_pkg::*;
#(
  parameter int ADDR_W = 4,
  parameter int PTR_W = 2
) (
  // register bus clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pixel clock
  input wire logic pixel_clk,
  // pixel port
  input wire logic pixel_latch_strobe_in,
  input wire logic [23:0] pixel_port_a,
  input wire logic [23:0] pixel_port_b,
  input wire logic sync_in,
  input wire logic blank_in,
  input wire logic [3:0] palette_select_inputs,
  // video outputs
  output logic [9:0] red_current_output,
  output logic [9:0] green_current_output,
  output logic [9:0] blue_current_output,
  output logic green_sync_level,
  output logic output_shutdown,
  output logic digital_sync_out,
  output logic pixel_latch_strobe_out
);

  localparam int DEPTH = 1 << PTR_W;

  // gray pointers need at least four slots to absorb any strobe phase
  if (PTR_W < 2 || PTR_W > 4) begin : g_bad_ptr
    $error("ppmc_top: PTR_W must be 2 to 4");
  end
  if (ADDR_W < 3) begin : g_bad_addr
    $error("ppmc_top: ADDR_W must be at least 3");
  end

  function automatic logic [PTR_W-1:0] bin2gray(input logic [PTR_W-1:0] b);
    return b ^ (b >> 1);
  endfunction

  function automatic logic [29:0] expand(input logic [1:0] fmt, input logic [23:0] p);
    logic [29:0] c;
    c = '0;
    case (fmt)
      `PPMC_FMT_15: c = {p[23:19], p[23:19], p[15:11], p[15:11], p[7:3], p[7:3]};
      `PPMC_FMT_8: c = {p[23:16], p[23:22], p[23:16], p[23:22], p[23:16], p[23:22]};
      default: c = {p[23:16], p[23:22], p[15:8], p[15:14], p[7:0], p[7:6]};
    endcase
    return c;
  endfunction

  // ---------------- register bus (aclk) ----------------
  ppmc_ctrl_s ctrl_r;
  logic aw_held_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic w_held_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic [1:0] stat_s;

  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready = !w_held_r && !bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      awaddr_r <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_r <= 1'b1;
      awaddr_r <= s_axi_awaddr;
    end else if (aw_held_r && w_held_r) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_r <= 1'b1;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end else if (aw_held_r && w_held_r) begin
      w_held_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= `PPMC_RESP_OKAY;
      ctrl_r <= `PPMC_CTRL_RESET;
    end else if (aw_held_r && w_held_r) begin
      bvalid_r <= 1'b1;
      if (awaddr_r == `PPMC_ADDR_CTRL) begin
        bresp_r <= `PPMC_RESP_OKAY;
        if (wstrb_r[0]) begin
          // rate bit also retimes the strobe output
          ctrl_r <= wdata_r[`PPMC_CTRL_WIDTH-1:0];
        end
      end else if (awaddr_r == `PPMC_ADDR_STAT) begin
        bresp_r <= `PPMC_RESP_OKAY;
      end else begin
        bresp_r <= `PPMC_RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= `PPMC_RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_r) begin
      rvalid_r <= 1'b1;
      rdata_r <= '0;
      rresp_r <= `PPMC_RESP_OKAY;
      if (s_axi_araddr == `PPMC_ADDR_CTRL) begin
        rdata_r[`PPMC_CTRL_WIDTH-1:0] <= ctrl_r;
      end else if (s_axi_araddr == `PPMC_ADDR_STAT) begin
        rdata_r[`PPMC_STAT_ACTIVE:`PPMC_STAT_SEL] <= stat_s;
      end else begin
        rresp_r <= `PPMC_RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ---------------- strobe domain capture ----------------
  logic srst_n;
  logic [PTR_W-1:0] wr_bin_r;
  logic [PTR_W-1:0] wr_gray_r;
  ppmc_pair_s ring [DEPTH];
  ppmc_pair_s capture;

  ppmc_sync #(.W(1)) u_srst (
    .clk(pixel_latch_strobe_in),
    .d(aresetn),
    .q(srst_n)
  );

  always_comb begin
    capture.pix_a = pixel_port_a;
    capture.pix_b = pixel_port_b;
    capture.ps_a = palette_select_inputs[1:0];
    capture.ps_b = palette_select_inputs[3:2];
    capture.sync = sync_in;
    capture.blank = blank_in;
  end

  // slot written on every strobe rise, 1:1 included
  always_ff @(posedge pixel_latch_strobe_in) begin
    ring[wr_bin_r] <= capture;
  end

  always_ff @(posedge pixel_latch_strobe_in) begin
    if (!srst_n) begin
      wr_bin_r <= '0;
      wr_gray_r <= '0;
    end else begin
      wr_bin_r <= wr_bin_r + 1'b1;
      wr_gray_r <= bin2gray(wr_bin_r + 1'b1);
    end
  end

  // ---------------- pixel clock domain ----------------
  logic prst_n;
  logic [PTR_W-1:0] wr_gray_s;
  logic [PTR_W-1:0] rd_bin_r;
  ppmc_ctrl_s cfg_s;
  ppmc_state_e state_r;
  ppmc_state_e state_nxt;
  ppmc_pair_s pair_r;
  logic avail;
  logic take;
  logic div_r;
  logic sel_r;
  logic act_r;
  logic [23:0] cur_pix;
  logic [1:0] cur_ps;

  ppmc_sync #(.W(1)) u_prst (
    .clk(pixel_clk),
    .d(aresetn),
    .q(prst_n)
  );

  // gray pointer: only one bit moves per strobe, so any phase is safe
  ppmc_sync #(.W(PTR_W)) u_wptr (
    .clk(pixel_clk),
    .d(wr_gray_r),
    .q(wr_gray_s)
  );

  // config is static in use; change it only while video is idle
  ppmc_sync #(.W(`PPMC_CTRL_WIDTH)) u_cfg (
    .clk(pixel_clk),
    .d(ctrl_r),
    .q(cfg_s)
  );

  ppmc_sync #(.W(2)) u_stat (
    .clk(aclk),
    .d({act_r, sel_r}),
    .q(stat_s)
  );

  assign avail = (wr_gray_s != bin2gray(rd_bin_r));

  always_comb begin
    state_nxt = state_r;
    take = 1'b0;
    case (state_r)
      PPMC_IDLE: begin
        take = avail;
        state_nxt = avail ? PPMC_FIRST : PPMC_IDLE;
      end
      PPMC_FIRST: begin
        if (cfg_s.rate_1to1) begin
          take = avail;
          state_nxt = avail ? PPMC_FIRST : PPMC_IDLE;
        end else begin
          state_nxt = PPMC_SECOND;
        end
      end
      PPMC_SECOND: begin
        take = avail;
        state_nxt = avail ? PPMC_FIRST : PPMC_IDLE;
      end
      default: begin
        state_nxt = PPMC_IDLE;
      end
    endcase
  end

  always_ff @(posedge pixel_clk) begin
    if (!prst_n) begin
      state_r <= PPMC_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge pixel_clk) begin
    if (!prst_n) begin
      rd_bin_r <= '0;
      pair_r <= '0;
    end else if (take) begin
      rd_bin_r <= rd_bin_r + 1'b1;
      pair_r <= ring[rd_bin_r];
    end
  end

  // second slot of the pair carries its own selects
  always_comb begin
    cur_pix = pair_r.pix_a;
    cur_ps = pair_r.ps_a;
    if (state_r == PPMC_SECOND) begin
      cur_pix = pair_r.pix_b;
      cur_ps = pair_r.ps_b;
    end
  end

  // single output register stage for every field keeps them aligned
  always_ff @(posedge pixel_clk) begin
    if (!prst_n) begin
      red_current_output <= `PPMC_DAC_ZERO;
      green_current_output <= `PPMC_DAC_ZERO;
      blue_current_output <= `PPMC_DAC_ZERO;
      green_sync_level <= 1'b0;
      output_shutdown <= 1'b0;
      digital_sync_out <= 1'b0;
      sel_r <= 1'b0;
    end else if (state_r == PPMC_IDLE) begin
      // no data: hold blanking level
      red_current_output <= `PPMC_DAC_ZERO;
      green_current_output <= `PPMC_DAC_ZERO;
      blue_current_output <= `PPMC_DAC_ZERO;
      green_sync_level <= 1'b0;
      output_shutdown <= 1'b0;
      digital_sync_out <= 1'b0;
    end else begin
      sel_r <= (cur_ps == {cfg_s.select_match_bit1, cfg_s.select_match_bit0});
      if (cur_ps != {cfg_s.select_match_bit1, cfg_s.select_match_bit0}) begin
        red_current_output <= `PPMC_DAC_ZERO;
        green_current_output <= `PPMC_DAC_ZERO;
        blue_current_output <= `PPMC_DAC_ZERO;
        green_sync_level <= 1'b0;
        output_shutdown <= 1'b1;
      end else if (pair_r.blank || (pair_r.sync && cfg_s.sync_on_green_enable)) begin
        red_current_output <= `PPMC_DAC_ZERO;
        green_current_output <= `PPMC_DAC_ZERO;
        blue_current_output <= `PPMC_DAC_ZERO;
        green_sync_level <= pair_r.sync && cfg_s.sync_on_green_enable;
        output_shutdown <= 1'b0;
      end else begin
        {red_current_output, green_current_output, blue_current_output} <=
          expand(cfg_s.fmt, cur_pix);
        green_sync_level <= 1'b0;
        output_shutdown <= 1'b0;
      end
      digital_sync_out <= pair_r.sync && cfg_s.sync_output_enable;
    end
  end

  always_ff @(posedge pixel_clk) begin
    if (!prst_n) begin
      act_r <= 1'b0;
    end else begin
      act_r <= (state_r != PPMC_IDLE);
    end
  end

  // strobe output: half rate in 2:1, the pixel clock itself in 1:1
  always_ff @(posedge pixel_clk) begin
    if (!prst_n) begin
      div_r <= 1'b0;
    end else begin
      div_r <= !div_r;
    end
  end

  // full rate during reset so a looped strobe still clears its own reset synchroniser
  assign pixel_latch_strobe_out = (!prst_n || cfg_s.rate_1to1) ? pixel_clk : div_r;

endmodule // ppmc_top

`default_nettype wire

// [sim/ppmc_top_assertions.sv]
`timescale 1ns/1ns
`default_nettype none

module ppmc_top_assertions (
  // register bus
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // video side
  input wire logic pixel_clk,
  input wire logic [9:0] red_current_output,
  input wire logic [9:0] green_current_output,
  input wire logic [9:0] blue_current_output,
  input wire logic green_sync_level,
  input wire logic output_shutdown
);
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  wr_answer_a: assert property (@(posedge aclk) disable iff (!aresetn) wr_take |=> ##1 s_axi_bvalid)
    else $error("write response late");
  rd_answer_a: assert property (@(posedge aclk) disable iff (!aresetn) rd_take |=> s_axi_rvalid)
    else $error("read response late");
  bresp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  rdata_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  aw_block_a: assert property (@(posedge aclk) disable iff (!aresetn) s_axi_bvalid |-> !s_axi_awready)
    else $error("write taken under response");
  ar_block_a: assert property (@(posedge aclk) disable iff (!aresetn) s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken under response");
  shut_zero_a: assert property (@(posedge pixel_clk) disable iff (!aresetn) output_shutdown |->
    red_current_output == 0 && green_current_output == 0 && blue_current_output == 0)
    else $error("deselected pixel not dark");
  sync_green_a: assert property (@(posedge pixel_clk) disable iff (!aresetn)
    green_sync_level |-> green_current_output == 0)
    else $error("sync level carries colour");
endmodule // ppmc_top_assertions

bind ppmc_top ppmc_top_assertions ppmc_top_assertions_inst (.*);

`default_nettype wire

// [sim/ppmc_fb_model.sv]
`timescale 1ns/1ns
`default_nettype none

module ppmc_fb_model
  import ppmc_pkg::*;
(
  // strobe loop
  input wire logic strobe_out,
  input wire logic run,
  output logic strobe_in,
  // pixel pair
  input wire ppmc_pair_s pair,
  output var ppmc_pair_s port
);
  // strobe loops straight back and stands still while halted
  assign strobe_in = strobe_out & run;
  initial port = '0;
  // data moves half a strobe away from capture
  always @(negedge strobe_out) begin
    port <= pair;
  end
endmodule // ppmc_fb_model

`default_nettype wire

// [sim/test_pixel_port_mux_capture.sv]
`include "ppmc_defines.svh"
`timescale 1ns/1ns
`default_nettype none

module test_pixel_port_mux_capture;
  import ppmc_pkg::*;
  // strobe runs through reset so the capture side can clear its pointers
  logic aclk = 0, aresetn = 0, pixel_clk = 0, run = 1;
  logic [3:0] awaddr = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0, rdata, d;
  logic awready, wready, bvalid, arready, rvalid, gsl, shut, dsync, stb_out, stb_in;
  logic [1:0] bresp, rresp, r;
  logic [9:0] red, grn, blu;
  ppmc_pair_s pair = '0, port;
  int n_mismatch = 0, n_tests = 0, cyc = 0;

  initial begin
    forever #50 aclk = ~aclk;
  end
  initial begin
    #2;
    forever #3 pixel_clk = ~pixel_clk;
  end

  ppmc_top ppmc_top_inst (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pixel_clk(pixel_clk), .pixel_latch_strobe_in(stb_in),
    .pixel_port_a(port.pix_a), .pixel_port_b(port.pix_b),
    .sync_in(port.sync), .blank_in(port.blank), .palette_select_inputs({port.ps_b, port.ps_a}),
    .red_current_output(red), .green_current_output(grn), .blue_current_output(blu),
    .green_sync_level(gsl), .output_shutdown(shut), .digital_sync_out(dsync),
    .pixel_latch_strobe_out(stb_out)
  );
  ppmc_fb_model ppmc_fb_model_inst (.strobe_out(stb_out), .run(run), .strobe_in(stb_in), .pair(pair), .port(port));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results;
    $display("mismatches %0d tests %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic ad, dd;
    ad = 0;
    dd = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!(ad && dd)) begin
      @(posedge aclk);
      if (awready) ad = 1;
      if (wready) dd = 1;
      if (ad) awvalid <= 0;
      if (dd) wvalid <= 0;
    end
    while (!bvalid) @(posedge aclk);
    rs = bresp;
    bready <= 0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge aclk); while (!arready);
    arvalid <= 0;
    while (!rvalid) @(posedge aclk);
    v = rdata;
    rs = rresp;
    rready <= 0;
  endtask

  // config only crosses while the strobe stands still
  task automatic cfg(input logic [31:0] c);
    @(posedge aclk);
    run <= 0;
    repeat (8) @(posedge aclk);
    wr(`PPMC_ADDR_CTRL, c, r);
    check(r, `PPMC_RESP_OKAY);
    repeat (8) @(posedge aclk);
    run <= 1;
  endtask

  task automatic seek(input logic [7:0] v);
    int k;
    k = 0;
    repeat (30) @(negedge pixel_clk);
    while (red[9:2] !== v && k < 40) begin
      @(negedge pixel_clk);
      k++;
    end
    check(red[9:2], v);
  endtask

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      results();
    end
  end

  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    rd(`PPMC_ADDR_CTRL, d, r);
    check(d, 0);
    rd(4'h8, d, r);
    check(r, `PPMC_RESP_SLVERR);
    wr(4'hC, 32'h7F, r);
    check(r, `PPMC_RESP_SLVERR);
    pair <= '{24'h5A1122, 24'hA53344, 2'b10, 2'b10, 1'b0, 1'b0};
    cfg(32'h08);
    rd(`PPMC_ADDR_CTRL, d, r);
    check(d, 32'h08);
    seek(8'h5A);
    check(grn[9:2], 8'h11);
    check(shut, 0);
    @(negedge pixel_clk);
    check(red[9:2], 8'hA5);
    check(blu[9:2], 8'h44);
    rd(`PPMC_ADDR_STAT, d, r);
    check(d[1:0], 2'b11);
    @(posedge aclk);
    pair.ps_a <= 2'b00;
    seek(8'hA5);
    check(shut, 0);
    @(negedge pixel_clk);
    check(shut, 1);
    check(red, 0);
    @(posedge aclk);
    pair <= '{24'h5A1122, 24'hA53344, 2'b10, 2'b10, 1'b1, 1'b1};
    for (int i = 1; i < 4; i++) begin
      cfg(32'h08 + i);
      repeat (40) @(negedge pixel_clk);
      repeat (2) begin
        @(negedge pixel_clk);
        check(red, 0);
        check(gsl, i[0]);
        check(dsync, i[1]);
      end
    end
    pair <= '{24'h3C5566, 24'hC37788, 2'b10, 2'b01, 1'b0, 1'b0};
    cfg(32'h58);
    seek(8'h3C);
    repeat (2) begin
      @(negedge pixel_clk);
      check(red[9:2], 8'h3C);
      check(grn[9:2], 8'h3C);
      check(blu[9:2], 8'h3C);
      check(shut, 0);
    end
    // back to 2:1 in 15-bit format; pixel B select does not match
    cfg(32'h28);
    seek(8'h39);
    check(red, 10'h0E7);
    check(grn, 10'h14A);
    check(blu, 10'h18C);
    @(negedge pixel_clk);
    check(shut, 1);
    results();
  end
endmodule // test_pixel_port_mux_capture

`default_nettype wire
